// File: core/lbdp_pkg.sv
// Constants and types for the local bus decode and protect block.
// Assumes both bus masters and the register port share one core clock.
package lbdp_pkg;
    // Segment numbers, address bits 31:28
    localparam logic [3:0] SEG_FLASH = 4'hA;
    localparam logic [3:0] SEG_OVL = 4'hC;
    localparam logic [3:0] SEG_LOCAL = 4'hD;
    localparam logic [3:0] SEG_RSV = 4'hE;
    localparam logic [3:0] SEG_PERIPH = 4'hF;
    // Windows as base and size in bytes
    localparam logic [31:0] PFL_BASE = 32'hA000_0000;
    localparam logic [31:0] PFL_SIZE = 32'h0018_0000;
    localparam logic [31:0] DFL0_BASE = 32'hAFE0_0000;
    localparam logic [31:0] DFL1_BASE = 32'hAFE1_0000;
    localparam logic [31:0] DFL_SIZE = 32'h0000_4000;
    localparam logic [31:0] BOOT_ROM_BASE = 32'hAFFF_C000;
    localparam logic [31:0] BOOT_ROM_SIZE = 32'h0000_4000;
    localparam logic [31:0] OVL_BASE = 32'hC000_0000;
    localparam logic [31:0] OVL_SIZE = 32'h0000_2000;
    localparam logic [31:0] LDR_BASE = 32'hD000_0000;
    localparam logic [31:0] LDR_SIZE = 32'h0000_E000;
    localparam logic [31:0] SPR_BASE = 32'hD400_0000;
    localparam logic [31:0] SPR_SIZE = 32'h0000_4000;
    localparam logic [31:0] SPR_RSV_SIZE = 32'h0400_0000;
    localparam logic [31:0] BRSV_BASE = 32'hDF00_0000;
    localparam logic [31:0] BRSV_SIZE = 32'h0100_0000;
    localparam logic [31:0] PER_BASE = 32'hF000_0000;
    localparam logic [31:0] PER_SIZE = 32'h0800_0000;
    localparam logic [31:0] PMU_BASE = 32'hF800_0500;
    localparam logic [31:0] FREG_BASE = 32'hF800_1000;
    localparam logic [31:0] FREG_SIZE = 32'h0000_1400;
    localparam logic [31:0] DMIR_BASE = 32'hF87F_FC00;
    localparam logic [31:0] PMIR_BASE = 32'hF87F_FD00;
    localparam logic [31:0] LOCAL_BUS_CONTROL_UNIT_BASE = 32'hF87F_FE00;
    localparam logic [31:0] BRG_BASE = 32'hF87F_FF00;
    localparam logic [31:0] UNIT_SIZE = 32'h0000_0100;
    // Protection register file
    localparam int unsigned SETS = 2;
    localparam int unsigned SLOTS = 8;
    localparam int unsigned CODE_SLOT0 = 4;
    localparam int unsigned ENTRIES = SETS * SLOTS;
    localparam int unsigned ENT_W = $clog2(ENTRIES);
    localparam int unsigned RA_W = 12;
    localparam logic [1:0] FLD_LOWER = 2'h0;
    localparam logic [1:0] FLD_UPPER = 2'h1;
    localparam logic [1:0] FLD_MODE = 2'h2;
    localparam logic [RA_W-1:0] REG_STATUS = 12'h100;
    localparam logic [RA_W-1:0] REG_MASK = 12'h104;
    localparam logic [RA_W-1:0] REG_CTRL = 12'h108;
    localparam logic [RA_W-1:0] REG_TRAP_ADDR = 12'h10C;
    localparam logic [RA_W-1:0] REG_TRAP_INFO = 12'h110;
    localparam int unsigned MODE_RD = 0;
    localparam int unsigned MODE_WR = 1;
    localparam int unsigned CTRL_EN = 0;
    localparam logic CTRL_EN_RST = 1'b0;
    // Event bits: code viol, data viol, program lerr, data lerr
    localparam int unsigned EV_W = 4;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;

    typedef enum logic [3:0] {
        TGT_NONE = 4'h0,
        TGT_PERIPH = 4'h1,
        TGT_PROGRAM_FLASH = 4'h2,
        TGT_DFLASH0 = 4'h3,
        TGT_DFLASH1 = 4'h4,
        TGT_BOOT_ROM = 4'h5,
        TGT_OVERLAY_RAM = 4'h6,
        TGT_LOCAL_DATA_RAM = 4'h7,
        TGT_PROGRAM_SCRATCH_RAM = 4'h8,
        TGT_PMU = 4'h9,
        TGT_FLREG = 4'hA,
        TGT_DMIREG = 4'hB,
        TGT_PMIREG = 4'hC,
        TGT_LOCAL_BUS_CONTROL_UNIT = 4'hD,
        TGT_BRIDGE = 4'hE
    } lbdp_tgt_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic flash_cmd;
        logic [31:0] addr;
    } lbdp_req_t;

    typedef struct packed {
        logic valid;
        lbdp_tgt_t tgt;
        logic cacheable;
        logic fail_trap;
        logic lerr_trap;
        logic prot_trap;
    } lbdp_rsp_t;
endpackage

// File: core/lbdp_decode.sv
// Combinational address map of the local bus for one master.
// Assumes the caller gates the result with the request valid.
`timescale 1ns/1ps
module lbdp_decode
    import lbdp_pkg::*;
(
    // Request
    input wire lbdp_req_t i_req,
    // Decode result
    output lbdp_tgt_t o_tgt,
    output logic o_lerr_trap,
    output logic o_fail_trap,
    output logic o_cacheable
);
    function automatic logic in_win(input logic [31:0] a,
        input logic [31:0] base, input logic [31:0] size);
        in_win = (a - base) < size;
    endfunction

    logic [31:0] a;
    logic wr;
    assign a = i_req.addr;
    assign wr = i_req.write;

    always_comb begin
        o_tgt = TGT_NONE;
        o_lerr_trap = 1'b0;
        o_fail_trap = 1'b0;
        o_cacheable = (a[31:28] == SEG_OVL); // [R15]
        case (a[31:28])
            SEG_FLASH: begin // [R17]
                if (in_win(a, PFL_BASE, PFL_SIZE)) begin
                    o_tgt = TGT_PROGRAM_FLASH;
                end else if (in_win(a, DFL0_BASE, DFL_SIZE)) begin
                    o_tgt = TGT_DFLASH0;
                end else if (in_win(a, DFL1_BASE, DFL_SIZE)) begin
                    o_tgt = TGT_DFLASH1;
                end else if (in_win(a, BOOT_ROM_BASE, BOOT_ROM_SIZE) && !wr) begin
                    o_tgt = TGT_BOOT_ROM;
                end else begin
                    o_lerr_trap = 1'b1; // [R16]
                end
                // Plain writes cannot update flash contents
                if (wr && !i_req.flash_cmd) begin // [R4]
                    o_tgt = TGT_NONE;
                    o_lerr_trap = 1'b1;
                end
            end
            SEG_OVL: begin
                if (in_win(a, OVL_BASE, OVL_SIZE)) begin
                    o_tgt = TGT_OVERLAY_RAM; // [R17]
                end else begin
                    o_lerr_trap = 1'b1; // [R16]
                end
            end
            SEG_LOCAL: begin
                if (in_win(a, LDR_BASE, LDR_SIZE)) begin
                    o_tgt = TGT_LOCAL_DATA_RAM; // [R17]
                end else if (in_win(a, SPR_BASE, SPR_SIZE)) begin
                    o_tgt = TGT_PROGRAM_SCRATCH_RAM; // [R6]
                end else begin
                    // Boot ROM reserve stays undecoded [R7]
                    o_lerr_trap = 1'b1; // [R16]
                end
            end
            SEG_RSV: o_lerr_trap = 1'b1; // [R16]
            SEG_PERIPH: begin
                if (in_win(a, PER_BASE, PER_SIZE)) begin
                    o_tgt = TGT_PERIPH; // [R2]
                    o_fail_trap = !wr; // [R3]
                end else if (in_win(a, PMU_BASE, UNIT_SIZE)) begin
                    o_tgt = TGT_PMU; // [R5]
                end else if (in_win(a, FREG_BASE, FREG_SIZE)) begin
                    o_tgt = TGT_FLREG;
                end else if (in_win(a, DMIR_BASE, UNIT_SIZE)) begin
                    o_tgt = TGT_DMIREG;
                end else if (in_win(a, PMIR_BASE, UNIT_SIZE)) begin
                    o_tgt = TGT_PMIREG;
                end else if (in_win(a, LOCAL_BUS_CONTROL_UNIT_BASE, UNIT_SIZE)) begin
                    o_tgt = TGT_LOCAL_BUS_CONTROL_UNIT;
                end else if (in_win(a, BRG_BASE, UNIT_SIZE)) begin
                    o_tgt = TGT_BRIDGE;
                end else begin
                    o_lerr_trap = 1'b1; // [R16]
                end
            end
            default: begin
                // Low segments and segment 11 go to the peripheral bus
                o_tgt = TGT_PERIPH;
                o_fail_trap = !wr;
            end
        endcase
    end
endmodule

// File: core/lbdp_range_chk.sv
// Range match of one access against a group of protection ranges.
// Assumes bounds and modes come from the active register set.
`timescale 1ns/1ps
module lbdp_range_chk
    import lbdp_pkg::*;
#(
    parameter int unsigned N = 4
)(
    // Access
    input wire logic [31:0] i_addr,
    input wire logic i_write,
    // Ranges
    input wire logic [N-1:0][31:0] i_lo,
    input wire logic [N-1:0][31:0] i_hi,
    input wire logic [N-1:0][1:0] i_mode,
    // Result
    output logic o_ok
);
    logic [N-1:0] hit;

    // Lower bound inclusive, upper bound exclusive
    for (genvar i = 0; i < N; i++) begin : g_rng
        assign hit[i] = (i_addr >= i_lo[i]) && (i_addr < i_hi[i]) &&
            i_mode[i][i_write ? MODE_WR : MODE_RD]; // [R12]
    end

    assign o_ok = |hit;
endmodule

// File: core/lbdp_top.sv
// Local bus address decode with range protection for two masters.
// Assumes requests come from logic on i_clk, one access per cycle each.
//
// Overview of operation
// R1: Serve program and data masters, same map.
// R2: Forward lower segment 15 to peripheral bus.
// R3: Forwarded reserved areas answer bus error.
// R4: Flash writes only within command sequences.
// R5: Route program memory unit register window.
// R6: Scratch RAM in segment 13, reserve traps.
// R7: Boot ROM reserve decoded to nothing.
// R8: Two protection register sets, 0 and 1.
// R9: Status word field selects active set.
// R10: Four data ranges per set.
// R11: Two code ranges per set.
// R12: Range is two bounds plus mode.
// R13: Illegal access is blocked and trapped.
// R14: Illegal access signalled to debug unit.
// R15: Overlay cacheable, other local segments not.
// R16: Reserved local ranges give bus error trap.
// R17: Route flash, boot ROM, overlay, data RAM.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module lbdp_top
    import lbdp_pkg::*;
#(
    parameter int unsigned N_DATA = 4,
    parameter int unsigned N_CODE = 2
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Program side master
    input wire lbdp_req_t i_pm_req,
    output lbdp_rsp_t o_pm_rsp,
    // Data side master
    input wire lbdp_req_t i_dm_req,
    output lbdp_rsp_t o_dm_rsp,
    // Active protection set
    input wire logic i_protection_set_select,
    // Register port
    input wire logic [RA_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Debug and interrupt
    output logic [1:0] o_dbg_viol,
    output logic o_irq
);
    if (N_DATA < 1 || N_DATA > CODE_SLOT0 || N_CODE < 1 ||
        N_CODE > SLOTS - CODE_SLOT0) begin : g_bad_cfg
        $error("lbdp_top: range count not supported");
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Protection register file, both sets
    logic [31:0] lo [ENTRIES];
    logic [31:0] hi [ENTRIES];
    logic [1:0] mode [ENTRIES];
    logic prot_en;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [31:0] trap_addr;
    logic [2:0] trap_info;
    lbdp_rsp_t rsp [2];
    logic [31:0] next_rdata;

    logic ent_hit;
    logic [ENT_W-1:0] ent_idx;
    logic [1:0] ent_fld;
    assign ent_hit = i_reg_addr < REG_STATUS;
    assign ent_idx = i_reg_addr[ENT_W+3:4];
    assign ent_fld = i_reg_addr[3:2];

    logic wr_status;
    assign wr_status = i_reg_wr && (i_reg_addr == REG_STATUS);

    // Both sets live side by side, one slot block each
    always_ff @(posedge i_clk or negedge i_rst_n) begin // [R8]
        if (!i_rst_n) begin
            for (int e = 0; e < ENTRIES; e++) begin
                lo[e] <= 32'h0000_0000;
                hi[e] <= 32'h0000_0000;
                mode[e] <= 2'h0;
            end
        end else if (i_reg_wr && ent_hit) begin
            case (ent_fld)
                FLD_LOWER: lo[ent_idx] <= i_reg_wdata; // [R12]
                FLD_UPPER: hi[ent_idx] <= i_reg_wdata;
                FLD_MODE: mode[ent_idx] <= i_reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prot_en <= CTRL_EN_RST;
        end else if (i_reg_wr && i_reg_addr == REG_CTRL) begin
            prot_en <= i_reg_wdata[CTRL_EN];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask <= MASK_RST;
        end else if (i_reg_wr && i_reg_addr == REG_MASK) begin
            mask <= i_reg_wdata[EV_W-1:0];
        end
    end

    // Active set selection
    logic [ENT_W-1:0] set_base;
    logic [N_DATA-1:0][31:0] d_lo;
    logic [N_DATA-1:0][31:0] d_hi;
    logic [N_DATA-1:0][1:0] d_mode;
    logic [N_CODE-1:0][31:0] c_lo;
    logic [N_CODE-1:0][31:0] c_hi;
    logic [N_CODE-1:0][1:0] c_mode;

    assign set_base = i_protection_set_select ?
        ENT_W'(SLOTS) : '0; // [R9]

    for (genvar i = 0; i < N_DATA; i++) begin : g_dsel // [R10]
        assign d_lo[i] = lo[set_base + ENT_W'(i)];
        assign d_hi[i] = hi[set_base + ENT_W'(i)];
        assign d_mode[i] = mode[set_base + ENT_W'(i)];
    end

    for (genvar i = 0; i < N_CODE; i++) begin : g_csel // [R11]
        assign c_lo[i] = lo[set_base + ENT_W'(CODE_SLOT0 + i)];
        assign c_hi[i] = hi[set_base + ENT_W'(CODE_SLOT0 + i)];
        assign c_mode[i] = mode[set_base + ENT_W'(CODE_SLOT0 + i)];
    end

    // Master 0 fetches code, master 1 moves data
    lbdp_req_t req [2];
    logic [1:0] ok;
    logic [1:0] viol;
    logic [1:0] lerr;
    assign req[0] = i_pm_req; // [R1]
    assign req[1] = i_dm_req;

    lbdp_range_chk #(
        .N(N_CODE)
    ) u_code_chk (
        .i_addr(req[0].addr),
        .i_write(1'b0),
        .i_lo(c_lo),
        .i_hi(c_hi),
        .i_mode(c_mode),
        .o_ok(ok[0])
    );

    lbdp_range_chk #(
        .N(N_DATA)
    ) u_data_chk (
        .i_addr(req[1].addr),
        .i_write(req[1].write),
        .i_lo(d_lo),
        .i_hi(d_hi),
        .i_mode(d_mode),
        .o_ok(ok[1])
    );

    for (genvar m = 0; m < 2; m++) begin : g_mst
        lbdp_tgt_t tgt;
        logic lerr_d;
        logic fail_d;
        logic cach_d;

        lbdp_decode u_dec (
            .i_req(req[m]),
            .o_tgt(tgt),
            .o_lerr_trap(lerr_d),
            .o_fail_trap(fail_d),
            .o_cacheable(cach_d)
        );

        // Protection is checked ahead of decode; a blocked access
        // never reaches any target
        assign viol[m] = req[m].valid && prot_en && !ok[m]; // [R13]
        assign lerr[m] = req[m].valid && !viol[m] && lerr_d;

        always_ff @(posedge i_clk or negedge i_rst_n) begin // [R1]
            if (!i_rst_n) begin
                rsp[m] <= '0;
            end else begin
                rsp[m].valid <= req[m].valid;
                rsp[m].prot_trap <= viol[m]; // [R13]
                rsp[m].lerr_trap <= lerr[m];
                if (req[m].valid && !viol[m]) begin
                    rsp[m].tgt <= tgt;
                    rsp[m].fail_trap <= fail_d;
                    rsp[m].cacheable <= cach_d;
                end else begin
                    rsp[m].tgt <= TGT_NONE;
                    rsp[m].fail_trap <= 1'b0;
                    rsp[m].cacheable <= 1'b0;
                end
            end
        end

        sequence s_clean;
            req[m].valid && !viol[m];
        endsequence

        rsp_latency_a: assert property ( // [R1]
            req[m].valid |=> rsp[m].valid ##1 !rsp[m].valid ||
                $past(req[m].valid))
            else $error("response did not follow request");

        prot_block_a: assert property ( // [R13]
            viol[m] |=> rsp[m].prot_trap && rsp[m].tgt == TGT_NONE)
            else $error("illegal access not blocked");

        periph_fwd_a: assert property ( // [R2]
            s_clean and req[m].addr[31:27] == PER_BASE[31:27]
            |=> rsp[m].tgt == TGT_PERIPH &&
                rsp[m].fail_trap != $past(req[m].write))
            else $error("segment 15 access not forwarded");

        pmu_route_a: assert property ( // [R5]
            s_clean and req[m].addr[31:8] == PMU_BASE[31:8]
            |=> rsp[m].tgt == TGT_PMU && !rsp[m].lerr_trap)
            else $error("unit window not routed");

        program_scratch_ram_rsv_a: assert property ( // [R6]
            s_clean and req[m].addr[31:26] == SPR_BASE[31:26] and
            req[m].addr[25:14] != '0
            |=> rsp[m].lerr_trap && rsp[m].tgt == TGT_NONE)
            else $error("scratch reserve did not trap");

        boot_rom_rsv_a: assert property ( // [R7]
            s_clean and req[m].addr[31:24] == BRSV_BASE[31:24]
            |=> rsp[m].tgt == TGT_NONE ##0 rsp[m].lerr_trap)
            else $error("boot reserve was decoded");

        flash_wr_a: assert property ( // [R4]
            s_clean and req[m].write and !req[m].flash_cmd and
            req[m].addr[31:28] == SEG_FLASH
            |=> rsp[m].lerr_trap)
            else $error("plain flash write accepted");

        cache_tag_a: assert property ( // [R15]
            s_clean |=> rsp[m].cacheable ==
                ($past(req[m].addr[31:28]) == SEG_OVL))
            else $error("cacheable tag wrong");
    end

    assign o_pm_rsp = rsp[0];
    assign o_dm_rsp = rsp[1];

    // Events: set wins over a write-one clear in the same cycle
    logic [EV_W-1:0] ev;
    assign ev = {lerr[1], lerr[0], viol[1], viol[0]};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status <= '0;
        end else begin
            status <= (status & ~(wr_status ?
                i_reg_wdata[EV_W-1:0] : '0)) | ev;
        end
    end

    // Data side wins when both masters fault together
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trap_addr <= 32'h0000_0000;
            trap_info <= 3'h0;
        end else if (viol[1]) begin
            trap_addr <= req[1].addr;
            trap_info <= {i_protection_set_select, req[1].write, 1'b1};
        end else if (viol[0]) begin
            trap_addr <= req[0].addr;
            trap_info <= {i_protection_set_select, 1'b0, 1'b0};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dbg_viol <= 2'h0;
        end else begin
            o_dbg_viol <= viol; // [R14]
        end
    end

    // One cycle behind the status bit, kept as a flop output
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status & mask);
        end
    end

    always_comb begin
        next_rdata = '0;
        if (ent_hit) begin
            case (ent_fld)
                FLD_LOWER: next_rdata = lo[ent_idx];
                FLD_UPPER: next_rdata = hi[ent_idx];
                FLD_MODE: next_rdata = {30'h0, mode[ent_idx]};
                default: next_rdata = '0;
            endcase
        end else begin
            case (i_reg_addr)
                REG_STATUS: next_rdata = {{(32-EV_W){1'b0}}, status};
                REG_MASK: next_rdata = {{(32-EV_W){1'b0}}, mask};
                REG_CTRL: next_rdata = {31'h0, prot_en};
                REG_TRAP_ADDR: next_rdata = trap_addr;
                REG_TRAP_INFO: next_rdata = {29'h0, trap_info};
                default: next_rdata = '0;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    dbg_pulse_a: assert property ( // [R14]
        viol != 2'h0 |=> o_dbg_viol == $past(viol))
        else $error("debug indication missing");

    sticky_a: assert property ( // [R13]
        viol[1] ##1 !wr_status |=> status[1])
        else $error("violation status not sticky");

    irq_a: assert property (
        (status & mask) != '0 |=> o_irq)
        else $error("interrupt not raised");
endmodule

// File: test/lbdp_master_model.sv
// Partner model of one local bus master, program or data side.
// Assumes the bench hands it one command per cycle on i_cmd.
`timescale 1ns/1ps
module lbdp_master_model
    import lbdp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Command from the bench
    input wire lbdp_req_t i_cmd,
    // Request toward the decoder
    output lbdp_req_t o_req
);
    // Idle bus toggles its address so a stale value never looks valid
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_req <= '0;
        end else if (i_cmd.valid) begin
            o_req <= i_cmd;
        end else begin
            o_req.valid <= 1'b0;
            o_req.write <= ~o_req.write;
            o_req.addr <= ~o_req.addr;
        end
    end
endmodule

// File: test/lbdp_top_tb.sv
// Self-checking bench for the local bus decode and protect block.
// Assumes one core clock; masters are modelled by lbdp_master_model.
`timescale 1ns/1ps
module lbdp_top_tb;
    import lbdp_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic psel = 1'b0;
    lbdp_req_t pm_cmd = '0;
    lbdp_req_t dm_cmd = '0;
    lbdp_req_t pm_req;
    lbdp_req_t dm_req;
    lbdp_rsp_t o_pm_rsp;
    lbdp_rsp_t o_dm_rsp;
    logic [RA_W-1:0] ra = '0;
    logic [31:0] wd = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [1:0] dbg;
    logic irq;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;

    lbdp_master_model pm_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cmd(pm_cmd), .o_req(pm_req));
    lbdp_master_model dm_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cmd(dm_cmd), .o_req(dm_req));
    lbdp_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pm_req(pm_req),
        .o_pm_rsp(o_pm_rsp), .i_dm_req(dm_req), .o_dm_rsp(o_dm_rsp),
        .i_protection_set_select(psel), .i_reg_addr(ra),
        .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_dbg_viol(dbg), .o_irq(irq));

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    task automatic check(input string n, input logic [31:0] s,
        input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            final_report;
        end
    end

    task automatic reg_wr(input logic [RA_W-1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        ra <= a;
        wd <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [RA_W-1:0] a, input logic [31:0] e);
        @(posedge i_clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        check("reg", rdata, e);
        @(posedge i_clk);
        #1;
        check("reg idle", rdata, 32'h0);
    endtask

    task automatic acc(input int s, input logic w, input logic f,
        input logic [31:0] a, input lbdp_rsp_t e);
        @(posedge i_clk);
        if (s == 0) pm_cmd <= '{1'b1, w, f, a};
        else dm_cmd <= '{1'b1, w, f, a};
        @(posedge i_clk);
        pm_cmd.valid <= 1'b0;
        dm_cmd.valid <= 1'b0;
        @(posedge i_clk);
        #1;
        check("rsp", {23'h0, (s == 0) ? o_pm_rsp : o_dm_rsp}, e);
        check("dbg", dbg[s], e.prot_trap);
    endtask

    // Same map on both masters, protection off
    task automatic dec(input logic [31:0] a, input logic w, input logic f,
        input lbdp_tgt_t t, input logic le, input logic fl, input logic c);
        acc(0, w, f, a, '{1'b1, t, c, fl, le, 1'b0});
        acc(1, w, f, a, '{1'b1, t, c, fl, le, 1'b0});
    endtask

    task automatic prot(input int s, input logic w, input logic [31:0] a,
        input lbdp_tgt_t t, input logic bad);
        if (bad) acc(s, w, 1'b0, a, '{1'b1, TGT_NONE, 1'b0, 1'b0, 1'b0, 1'b1});
        else acc(s, w, 1'b0, a, '{1'b1, t, 1'b0, 1'b0, 1'b0, 1'b0});
    endtask

    task automatic t_decode;
        dec(32'hF800_0500, 1'b1, 1'b0, TGT_PMU, 1'b0, 1'b0, 1'b0);
        dec(32'hF800_05FF, 1'b0, 1'b0, TGT_PMU, 1'b0, 1'b0, 1'b0);
        dec(32'hF800_0600, 1'b0, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
        dec(32'hF000_0000, 1'b0, 1'b0, TGT_PERIPH, 1'b0, 1'b1, 1'b0);
        dec(32'hF7FF_FFFC, 1'b1, 1'b0, TGT_PERIPH, 1'b0, 1'b0, 1'b0);
        dec(32'hB000_0000, 1'b0, 1'b0, TGT_PERIPH, 1'b0, 1'b1, 1'b0);
        dec(32'hA000_0000, 1'b1, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
        dec(32'hA017_FFFC, 1'b1, 1'b1, TGT_PROGRAM_FLASH, 1'b0, 1'b0, 1'b0);
        dec(32'hAFE0_0000, 1'b0, 1'b0, TGT_DFLASH0, 1'b0, 1'b0, 1'b0);
        dec(32'hAFE1_3FFC, 1'b1, 1'b1, TGT_DFLASH1, 1'b0, 1'b0, 1'b0);
        dec(32'hAFE0_4000, 1'b0, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
        dec(32'hAFFF_C000, 1'b0, 1'b0, TGT_BOOT_ROM, 1'b0, 1'b0, 1'b0);
        dec(32'hC000_1FFC, 1'b1, 1'b0, TGT_OVERLAY_RAM, 1'b0, 1'b0, 1'b1);
        dec(32'hC000_2000, 1'b0, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b1);
        dec(32'hD000_DFFC, 1'b0, 1'b0, TGT_LOCAL_DATA_RAM, 1'b0, 1'b0, 1'b0);
        dec(32'hD400_3FFC, 1'b1, 1'b0, TGT_PROGRAM_SCRATCH_RAM, 1'b0, 1'b0, 1'b0);
        dec(32'hD400_4000, 1'b0, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
        dec(32'hDF00_0000, 1'b0, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
        dec(32'hE800_0000, 1'b1, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
        dec(32'hF87F_FC00, 1'b0, 1'b0, TGT_DMIREG, 1'b0, 1'b0, 1'b0);
        dec(32'hF87F_FF00, 1'b1, 1'b0, TGT_BRIDGE, 1'b0, 1'b0, 1'b0);
        dec(32'hF880_0000, 1'b0, 1'b0, TGT_NONE, 1'b1, 1'b0, 1'b0);
    endtask

    task automatic t_protect;
        reg_rd(REG_CTRL, 32'h0);
        reg_rd(REG_MASK, 32'h0);
        reg_rd(12'h200, 32'h0);
        reg_wr(12'h000, 32'hD000_0000);
        reg_wr(12'h004, 32'hD000_1000);
        reg_wr(12'h008, 32'h3);
        reg_wr(12'h030, 32'hD000_2000);
        reg_wr(12'h034, 32'hD000_3000);
        reg_wr(12'h038, 32'h1);
        reg_wr(12'h040, 32'hD400_0000);
        reg_wr(12'h044, 32'hD400_1000);
        reg_wr(12'h048, 32'h1);
        reg_wr(12'h080, 32'hD000_0000);
        reg_wr(12'h084, 32'hD000_1000);
        reg_wr(12'h088, 32'h1);
        reg_wr(REG_CTRL, 32'h1);
        reg_rd(12'h004, 32'hD000_1000);
        prot(1, 1'b1, 32'hD000_0FFC, TGT_LOCAL_DATA_RAM, 1'b0);
        prot(1, 1'b1, 32'hD000_1000, TGT_LOCAL_DATA_RAM, 1'b1);
        prot(1, 1'b1, 32'hD000_2000, TGT_LOCAL_DATA_RAM, 1'b1);
        prot(1, 1'b0, 32'hD000_2000, TGT_LOCAL_DATA_RAM, 1'b0);
        prot(0, 1'b0, 32'hD400_0000, TGT_PROGRAM_SCRATCH_RAM, 1'b0);
        prot(0, 1'b0, 32'hD400_1000, TGT_PROGRAM_SCRATCH_RAM, 1'b1);
        reg_rd(REG_TRAP_ADDR, 32'hD400_1000);
        @(posedge i_clk);
        psel <= 1'b1;
        prot(1, 1'b1, 32'hD000_0000, TGT_LOCAL_DATA_RAM, 1'b1);
        prot(1, 1'b0, 32'hD000_0000, TGT_LOCAL_DATA_RAM, 1'b0);
        prot(0, 1'b0, 32'hD400_0000, TGT_PROGRAM_SCRATCH_RAM, 1'b1);
        reg_rd(REG_TRAP_INFO, 32'h4);
        // Decode errors of the decode scenario left bits 2 and 3 set
        reg_rd(REG_STATUS, 32'hF);
        check("irq", irq, 1'b0);
        reg_wr(REG_MASK, 32'h2);
        repeat (2) @(posedge i_clk);
        #1;
        check("irq", irq, 1'b1);
        reg_wr(REG_STATUS, 32'hF);
        repeat (2) @(posedge i_clk);
        #1;
        check("irq", irq, 1'b0);
        reg_rd(REG_STATUS, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_decode;
        t_protect;
        final_report;
    end
endmodule
